// ### rtl/sram_host_ctrl.sv
// Purpose : host controller that drives a battery-backed 32K x 8 async static memory through its pins
// Assumes : one 250 MHz clock; memory pins are asynchronous; power-good comes from a supply monitor
// Notes   : one access at a time; write is select-and-write-strobe together, output gate held high
//
// What this block does
// - write spans later falling to earlier rising of the two strobes
// - master holds address whole write, valid 60 ns before write end
// - master raises a strobe, 0 ns recovery, before the next access
// - master sets data 30 ns before write end, holds 5 ns after
// - master keeps output gate high during writes
// - master holds write strobe 50 ns, select 55 ns, cycle 70 ns
`default_nettype none
module sram_host_ctrl
#(
   parameter longint RECOVERY_CYC = sram_port_pkg::POWER_UP_RECOVERY_CYC
)
(
   // clock and reset
   input  wire logic                              sys_clk_in,
   input  wire logic                              rst_in,
   // user request
   input  wire logic                              req_valid_in,
   input  wire logic                              req_write_in,
   input  wire logic [sram_port_pkg::ADDR_W-1:0]  req_addr_in,
   input  wire logic [sram_port_pkg::DATA_W-1:0]  req_wdata_in,
   output logic                                   req_ready_out,
   // user answer
   output logic                                   rsp_valid_out,
   output logic [sram_port_pkg::DATA_W-1:0]       rsp_rdata_out,
   output logic                                   mem_usable_out,
   // supply monitor, asynchronous
   input  wire logic                              power_good_in,
   // memory pins
   output logic [sram_port_pkg::ADDR_W-1:0]       addr_out,
   output logic                                   chip_enable_n_out,
   output logic                                   output_enable_n_out,
   output logic                                   write_enable_n_out,
   input  wire logic [sram_port_pkg::DATA_W-1:0]  data_io_in,
   output logic [sram_port_pkg::DATA_W-1:0]       data_io_out,
   output logic                                   data_io_oe_out
);
   // =====================================================================
   // states
   typedef enum logic [6:0]
   {
      ST_RECOVER = 7'h01,
      ST_IDLE    = 7'h02,
      ST_RD      = 7'h04,
      ST_RD_END  = 7'h08,
      ST_WR      = 7'h10,
      ST_WR_HOLD = 7'h20,
      ST_GAP     = 7'h40
   } state_t;

   // read window also covers the three extra cycles of the data synchroniser
   localparam int         SYNC_LAT  = 3;
   localparam logic [7:0] READ_CNT  = 8'(sram_port_pkg::READ_ACCESS_CYC - 1 + SYNC_LAT);
   localparam logic [7:0] FLOAT_CNT = 8'(sram_port_pkg::FLOAT_CYC - 1);
   localparam logic [7:0] WLOW_CNT  = 8'(sram_port_pkg::WRITE_LOW_CYC - 1);
   localparam logic [7:0] HOLD_CNT  = 8'(sram_port_pkg::DATA_HOLD_CYC - 1);
   localparam logic [7:0] GAP_CNT   = 8'(sram_port_pkg::CYCLE_CYC - 1);

   state_t                              state_q, state_d;
   logic [sram_port_pkg::CNT_W-1:0]     cnt_q, cnt_d;
   logic [31:0]                         rec_q;
   logic [sram_port_pkg::ADDR_W-1:0]    addr_q;
   logic [sram_port_pkg::DATA_W-1:0]    wdata_q, rdata_q;
   logic                                ce_n_q, oe_n_q, we_n_q, oe_q;
   logic                                rsp_q, ready_q, usable_q;
   logic                                pg_sync;
   logic [sram_port_pkg::DATA_W-1:0]    rd_sync;

   // =====================================================================
   // synchronise the power-good level and the data pins
   pin_sync #(.WIDTH(1)) u_pg_sync
   (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .async_in   (power_good_in),
      .sync_out   (pg_sync)
   );
   pin_sync #(.WIDTH(sram_port_pkg::DATA_W)) u_rd_sync
   (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .async_in   (data_io_in),
      .sync_out   (rd_sync)
   );

   // =====================================================================
   // decode
   wire cnt_done = (cnt_q == '0);
   wire rec_done = (rec_q >= 32'(RECOVERY_CYC));
   wire take     = (state_q == ST_IDLE) && req_valid_in && pg_sync;
   wire [7:0] cnt_dec = cnt_q - 8'h01;

   // =====================================================================
   // next-state logic
   always_comb
   begin
      state_d = state_q;
      cnt_d   = cnt_done ? cnt_q : cnt_dec;
      case (state_q)
         // hold off while the device is deselected
         ST_RECOVER: if (pg_sync && rec_done) state_d = ST_IDLE;
         ST_IDLE:
         begin
            if (!pg_sync)
               state_d = ST_RECOVER;
            else if (take)
            begin
               state_d = req_write_in ? ST_WR : ST_RD;
               cnt_d   = req_write_in ? WLOW_CNT : READ_CNT;
            end
         end
         // wait out the slowest access path before sampling
         ST_RD: if (cnt_done)
         begin
            state_d = ST_RD_END;
            cnt_d   = FLOAT_CNT;
         end
         // let the device float before the bus is reused
         ST_RD_END: if (cnt_done) state_d = ST_IDLE;
         ST_WR: if (cnt_done)
         begin
            state_d = ST_WR_HOLD;
            cnt_d   = HOLD_CNT;
         end
         // data held after the ending edge
         ST_WR_HOLD: if (cnt_done)
         begin
            state_d = ST_GAP;
            cnt_d   = GAP_CNT - WLOW_CNT - HOLD_CNT - 8'h02;
         end
         ST_GAP: if (cnt_done) state_d = ST_IDLE;
         default: state_d = ST_RECOVER;
      endcase
      // a supply loss abandons everything and re-enters recovery
      if (!pg_sync) state_d = ST_RECOVER;
   end

   // =====================================================================
   // pin levels per state
   wire in_rd = (state_q == ST_RD);
   // on a write, select and write strobe fall and rise together; a read lowers select and output gate together
   wire ce_n_d = !((state_d == ST_RD) || (state_d == ST_WR));
   // output gate only low for reads
   wire oe_n_d = !(state_d == ST_RD);
   wire we_n_d = !(state_d == ST_WR);
   // master drives data only through the write and its hold
   wire oe_d   = (state_d == ST_WR) || (state_d == ST_WR_HOLD);

   // =====================================================================
   // recovery counter
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in || !pg_sync)
         rec_q <= '0;
      else if (!rec_done)
         rec_q <= rec_q + 32'h0000_0001;
   end

   // =====================================================================
   // state, strobes, address and data registers
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         state_q  <= ST_RECOVER;
         cnt_q    <= '0;
         ce_n_q   <= 1'b1;
         oe_n_q   <= 1'b1;
         we_n_q   <= 1'b1;
         oe_q     <= 1'b0;
         addr_q   <= '0;
         wdata_q  <= '0;
         rdata_q  <= '0;
         rsp_q    <= 1'b0;
         ready_q  <= 1'b0;
         usable_q <= 1'b0;
      end
      else
      begin
         state_q  <= state_d;
         cnt_q    <= cnt_d;
         ce_n_q   <= ce_n_d;
         oe_n_q   <= oe_n_d;
         we_n_q   <= we_n_d;
         oe_q     <= oe_d;
         ready_q  <= (state_d == ST_IDLE);
         usable_q <= (state_d != ST_RECOVER);
         // address latched once, stable whole access
         if (take)
         begin
            addr_q  <= req_addr_in;
            wdata_q <= req_wdata_in;
         end
         // read data captured at end of access
         rsp_q <= in_rd && cnt_done && pg_sync;
         if (in_rd && cnt_done)
            rdata_q <= rd_sync;
      end
   end

   // =====================================================================
   // outputs straight from flip-flops
   assign req_ready_out       = ready_q;
   assign rsp_valid_out       = rsp_q;
   assign rsp_rdata_out       = rdata_q;
   assign mem_usable_out      = usable_q;
   assign addr_out            = addr_q;
   assign chip_enable_n_out   = ce_n_q;
   assign output_enable_n_out = oe_n_q;
   assign write_enable_n_out  = we_n_q;
   assign data_io_out         = wdata_q;
   assign data_io_oe_out      = oe_q;
endmodule // sram_host_ctrl
`default_nettype wire

// ### rtl/sram_port_pkg.sv
// Purpose : constants for the host-side controller of a battery-backed 32K x 8 async static memory
// Assumes : 250 MHz system clock, 4 ns period
// Notes   : times are in ns or ms as printed; cycle counts derive from them
`default_nettype none
package sram_port_pkg;
   // =====================================================================
   // geometry
   localparam int ADDR_W = 15;
   localparam int DATA_W = 8;
   // =====================================================================
   // clock
   localparam int CLK_PERIOD_NS = 4;
   // =====================================================================
   // read timing (ns)
   localparam int ADDR_ACCESS_DELAY_NS        = 70;
   localparam int SELECT_ACCESS_DELAY_NS      = 70;
   localparam int OUTPUT_GATE_ACCESS_DELAY_NS = 35;
   localparam int OUTPUT_HOLD_AFTER_ADDR_NS   = 10;
   localparam int DESELECT_FLOAT_DELAY_NS     = 25;
   localparam int WRITE_FLOAT_DELAY_NS        = 25;
   // =====================================================================
   // write timing (ns)
   localparam int CYCLE_TIME_NS          = 70;
   localparam int WRITE_PULSE_NS         = 50;
   localparam int SELECT_PULSE_NS        = 55;
   localparam int ADDR_TO_END_NS         = 60;
   localparam int WRITE_DATA_SETUP_NS    = 30;
   localparam int WRITE_DATA_HOLD_NS     = 5;
   localparam int WRITE_STROBE_RECOVERY_NS = 0;
   // =====================================================================
   // power-up recovery (ms), least value
   localparam int POWER_UP_RECOVERY_MS = 40;
   // =====================================================================
   // derived cycle counts: least times round up, at least one cycle
   function automatic int cyc_up(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction
   // read: latest valid point, plus one sampling cycle margin
   localparam int READ_ACCESS_CYC = cyc_up(ADDR_ACCESS_DELAY_NS) + 1;
   // turnaround after a read before the master drives the bus
   localparam int FLOAT_CYC       = cyc_up(DESELECT_FLOAT_DELAY_NS);
   localparam int WRITE_LOW_CYC   = cyc_up(SELECT_PULSE_NS > ADDR_TO_END_NS ? SELECT_PULSE_NS : ADDR_TO_END_NS);
   localparam int DATA_HOLD_CYC   = cyc_up(WRITE_DATA_HOLD_NS);
   localparam int CYCLE_CYC       = cyc_up(CYCLE_TIME_NS);
   // 40 ms at 4 ns is 10,000,000 cycles
   localparam longint POWER_UP_RECOVERY_CYC =
      (longint'(POWER_UP_RECOVERY_MS) * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 8;
endpackage
`default_nettype wire

// ### rtl/pin_sync.sv
// Purpose : three-stage synchroniser with agreement filter
// Assumes : input is asynchronous to sys_clk_in
// Notes   : the first stage feeds only the second
`default_nettype none
module pin_sync
#(
   parameter int WIDTH = 1
)
(
   // clock and reset
   input  wire logic             sys_clk_in,
   input  wire logic             rst_in,
   // pins
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;
   logic [WIDTH-1:0] out_q;
   // =====================================================================
   // per bit: accept a change once stages two and three agree
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_bit
         always_ff @(posedge sys_clk_in)
         begin
            if (rst_in)
            begin
               s1_q[i]  <= 1'b0;
               s2_q[i]  <= 1'b0;
               s3_q[i]  <= 1'b0;
               out_q[i] <= 1'b0;
            end
            else
            begin
               s1_q[i] <= async_in[i];
               s2_q[i] <= s1_q[i];
               s3_q[i] <= s2_q[i];
               if (s2_q[i] == s3_q[i])
                  out_q[i] <= s3_q[i];
            end
         end
      end
   endgenerate
   assign sync_out = out_q;
endmodule // pin_sync
`default_nettype wire

// ### test/sram_host_monitor.sv
// Purpose : pin-level protocol checks for the memory host controller
// Assumes : one clock domain, bound into the controller
// Notes   : counters measure strobe widths in clock cycles
`default_nettype none
// ====================
// checker
module sram_host_monitor
#(
   parameter longint RECOVERY_CYC = 50
)
(
   // clock, reset and user side
   input wire logic        sys_clk_in,
   input wire logic        rst_in,
   input wire logic        req_valid_in,
   input wire logic        req_write_in,
   input wire logic        req_ready_out,
   input wire logic        rsp_valid_out,
   input wire logic        mem_usable_out,
   input wire logic        power_good_in,
   // memory pins
   input wire logic [14:0] addr_out,
   input wire logic        chip_enable_n_out,
   input wire logic        output_enable_n_out,
   input wire logic        write_enable_n_out,
   input wire logic [7:0]  data_io_out,
   input wire logic        data_io_oe_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0]  we_lo_q;
   logic [7:0]  ce_lo_q;
   logic [31:0] pg_q;
   logic        pg_ok;
   // an aborted access is exempt from width checks
   assign pg_ok = (pg_q != 32'h0);
   // strobe-low and supply-good cycle counts
   always_ff @(posedge sys_clk_in)
   begin
      we_lo_q <= (rst_in || write_enable_n_out) ? 8'h00 : we_lo_q + 8'h01;
      ce_lo_q <= (rst_in || chip_enable_n_out) ? 8'h00 : ce_lo_q + 8'h01;
      pg_q    <= (rst_in || !power_good_in) ? 32'h0 : pg_q + 32'h1;
   end
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   a_write_addr_hold:
   assert property (!write_enable_n_out && !$past(write_enable_n_out) |-> $stable(addr_out))
      else $error("address moved during write");
   a_write_data_hold:
   assert property (!write_enable_n_out && !$past(write_enable_n_out) |-> $stable(data_io_out) && data_io_oe_out)
      else $error("write data moved during write");
   a_gate_off_write:
   assert property (!write_enable_n_out || data_io_oe_out |-> output_enable_n_out)
      else $error("output gate low while host drives");
   a_we_pulse_width:
   assert property ($rose(write_enable_n_out) && pg_ok |-> we_lo_q >= 8'h0D && ce_lo_q >= 8'h0E)
      else $error("write strobe too short");
   a_read_strobe_len:
   assert property ($rose(chip_enable_n_out) && !$past(output_enable_n_out) && pg_ok |-> ce_lo_q >= 8'h12)
      else $error("read window shorter than access time");
   a_data_after_end:
   assert property ($rose(write_enable_n_out) && pg_ok |-> data_io_oe_out && $stable(data_io_out) ##1 data_io_oe_out)
      else $error("write data not held after strobe");
   a_read_answer:
   assert property (req_valid_in && req_ready_out && !req_write_in && pg_ok |-> ##23 rsp_valid_out)
      else $error("read answer late or missing");
   a_idle_recovery:
   assert property (!mem_usable_out && !$past(mem_usable_out, 2) |-> chip_enable_n_out && write_enable_n_out)
      else $error("access during recovery");
   a_recovery_span:
   assert property ($rose(mem_usable_out) |-> pg_q >= RECOVERY_CYC)
      else $error("recovery ended early");
   c_read_done: cover property (rsp_valid_out);
   c_write_end: cover property ($rose(write_enable_n_out));
   c_power_loss: cover property ($fell(mem_usable_out));
endmodule // sram_host_monitor
bind sram_host_ctrl sram_host_monitor #(.RECOVERY_CYC(RECOVERY_CYC)) u_sram_host_monitor (.sys_clk_in, .rst_in,
   .req_valid_in, .req_write_in, .req_ready_out, .rsp_valid_out, .mem_usable_out, .power_good_in, .addr_out,
   .chip_enable_n_out, .output_enable_n_out, .write_enable_n_out, .data_io_out, .data_io_oe_out);
`default_nettype wire

// ### test/sram_dev_model.sv
// Purpose : behavioural model of the battery-backed byte memory
// Assumes : pins are asynchronous; times in ns
// Notes   : floating pins show a toggling pattern
`default_nettype none
// ====================
// memory model
module sram_dev_model
#(
   parameter int REC_NS = 200
)
(
   // memory pins
   input  wire logic [14:0] addr_in,
   input  wire logic        chip_enable_n_in,
   input  wire logic        output_enable_n_in,
   input  wire logic        write_enable_n_in,
   input  wire logic [7:0]  data_in,
   input  wire logic        power_good_in,
   output var  logic [7:0]  data_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] mem [0:32767];
   logic [7:0] last_q = 8'h00;
   logic       live = 1'b0;
   realtime    t_a = 0.0, t_e = 0.0, t_g = 0.0, t_p = 0.0, now;
   initial
   begin
      foreach (mem[i])
         mem[i] = 8'h00;
      data_out = 8'h5A;
   end
   // edge timestamps
   always @(addr_in) t_a = $realtime;
   always @(negedge chip_enable_n_in) t_e = $realtime;
   always @(negedge output_enable_n_in) t_g = $realtime;
   always @(posedge power_good_in) t_p = $realtime;
   // pin driver, re-evaluated every ns
   always #1
   begin
      now = $realtime;
      live = power_good_in && (now - t_p >= REC_NS);
      if (!live || chip_enable_n_in || output_enable_n_in || !write_enable_n_in)
         data_out = ~data_out;
      else if (now - t_a >= 70 && now - t_e >= 70 && now - t_g >= 35)
      begin
         data_out = mem[addr_in];
         last_q = data_out;
      end
      else if (now - t_a < 10)
         data_out = last_q;
      else
         data_out = ~data_out;
   end
   always @(posedge (chip_enable_n_in | write_enable_n_in))
   begin
      if (live)
         mem[addr_in] = data_in;
   end
endmodule // sram_dev_model
`default_nettype wire

// ### test/tb.sv
// Purpose : self-checking bench for the memory host controller
// Assumes : 250 MHz clock, short recovery parameter
// Notes   : read answers are matched against a queue of notes
`default_nettype none
// ====================
// bench
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int REC = 50;
   logic        sys_clk_in, rst_in, req_valid_in, req_write_in, power_good_in;
   logic        req_ready_out, rsp_valid_out, mem_usable_out, data_io_oe_out;
   logic        chip_enable_n_out, output_enable_n_out, write_enable_n_out;
   logic [14:0] req_addr_in, addr_out;
   logic [7:0]  req_wdata_in, rsp_rdata_out, data_io_out, dev_data, bus, old;
   logic [31:0] xs;
   logic [7:0]  shadow [logic [14:0]];
   logic [7:0]  expq [$];
   logic [14:0] aq [$];
   int          errors, total_checks, n;
   // wire level: host drive wins when enabled
   assign bus = data_io_oe_out ? data_io_out : dev_data;
   sram_host_ctrl #(.RECOVERY_CYC(REC)) u_sram_host_ctrl (.sys_clk_in, .rst_in, .req_valid_in, .req_write_in,
      .req_addr_in, .req_wdata_in, .req_ready_out, .rsp_valid_out, .rsp_rdata_out, .mem_usable_out,
      .power_good_in, .addr_out, .chip_enable_n_out, .output_enable_n_out, .write_enable_n_out,
      .data_io_in(bus), .data_io_out, .data_io_oe_out);
   sram_dev_model u_sram_dev_model (.addr_in(addr_out), .chip_enable_n_in(chip_enable_n_out),
      .output_enable_n_in(output_enable_n_out), .write_enable_n_in(write_enable_n_out), .data_in(bus),
      .power_good_in, .data_out(dev_data));
   function automatic logic [31:0] nxt(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   task automatic chk(input logic ok, input string msg);
      total_checks++;
      if (ok !== 1'b1)
      begin
         errors++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask
   // one request, taken when ready is seen high
   task automatic do_req(input logic w, input logic [14:0] a, input logic [7:0] d);
      int k;
      k = 0;
      @(negedge sys_clk_in);
      while (req_ready_out !== 1'b1 && k < 1000)
      begin
         @(negedge sys_clk_in);
         k++;
      end
      if (w)
         shadow[a] = d;
      else
         expq.push_back(shadow[a]);
      @(posedge sys_clk_in);
      req_valid_in <= 1'b1;
      req_write_in <= w;
      req_addr_in <= a;
      req_wdata_in <= d;
      @(posedge sys_clk_in);
      req_valid_in <= 1'b0;
   endtask
   task automatic wait_up(output int c);
      c = 0;
      while (mem_usable_out !== 1'b1 && c < 1000)
      begin
         @(negedge sys_clk_in);
         c++;
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      sys_clk_in = 1'b0;
      forever #2 sys_clk_in = ~sys_clk_in;
   end
   // answer watcher: oldest note against each pulse
   always @(negedge sys_clk_in)
   begin
      if (rsp_valid_out === 1'b1)
         chk(expq.size() != 0 && rsp_rdata_out === expq.pop_front(), "read data mismatch");
   end
   initial
   begin
      repeat (20000) @(posedge sys_clk_in);
      errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      give_verdict();
   end
   initial
   begin
      errors = 0;
      total_checks = 0;
      xs = 32'h1048;
      rst_in = 1'b1;
      power_good_in = 1'b1;
      req_valid_in = 1'b0;
      req_write_in = 1'b0;
      req_addr_in = 15'h0000;
      req_wdata_in = 8'h00;
      repeat (20) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      repeat (10) @(negedge sys_clk_in);
      chk(req_ready_out === 1'b0 && chip_enable_n_out === 1'b1, "access during recovery");
      wait_up(n);
      aq = '{15'h0000, 15'h7FFF, 15'h5555, 15'h2AAA};
      repeat (6)
      begin
         xs = nxt(xs);
         aq.push_back(xs[14:0]);
      end
      foreach (aq[i])
      begin
         xs = nxt(xs);
         do_req(1'b1, aq[i], xs[7:0]);
      end
      foreach (aq[i])
         do_req(1'b0, aq[i], 8'h00);
      // stray request while busy is ignored
      do_req(1'b1, 15'h0000, 8'hA5);
      @(posedge sys_clk_in);
      req_valid_in <= 1'b1;
      req_wdata_in <= 8'h3C;
      @(posedge sys_clk_in);
      req_valid_in <= 1'b0;
      do_req(1'b0, 15'h0000, 8'h00);
      // supply loss in mid-write
      old = shadow[15'h7FFF];
      do_req(1'b1, 15'h7FFF, ~old);
      shadow[15'h7FFF] = old;
      repeat (2) @(posedge sys_clk_in);
      power_good_in <= 1'b0;
      repeat (12) @(negedge sys_clk_in);
      chk(mem_usable_out === 1'b0 && req_ready_out === 1'b0 && chip_enable_n_out === 1'b1, "access at low supply");
      @(posedge sys_clk_in);
      power_good_in <= 1'b1;
      wait_up(n);
      chk(n >= REC && n < 1000, "recovery span wrong");
      foreach (aq[i])
         do_req(1'b0, aq[i], 8'h00);
      repeat (40) @(negedge sys_clk_in);
      chk(expq.size() == 0, "read answers missing");
      give_verdict();
   end
endmodule // tb
`default_nettype wire
